// ===== rtl/bit_sync.sv
// two-flop level synchroniser for a bus of independent levels
// assumes each bit is a slow level; no bus coherency is promised
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_t;

  sync_t sync_ff;
  sync_t nxt_sync;

  // first stage feeds only the second stage
  always_comb begin
    nxt_sync        = sync_ff;
    nxt_sync.meta   = din;
    nxt_sync.stable = sync_ff.meta;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign dout = sync_ff.stable;

endmodule

// ===== rtl/scan_tap_pkg.sv
// constants, state encoding and instruction codes for the sram boundary scan port
// assumes a test clock of at most 10 mhz from an external scan controller
package scan_tap_pkg;

  // -------------------------------------------------------------------------
  // widths and sizes
  // -------------------------------------------------------------------------
  localparam int IR_LEN       = 3;
  localparam int ID_LEN       = 32;
  localparam int RING_LEN_X18 = 51;
  localparam int RING_LEN_X36 = 70;
  localparam int RESET_TMS_EDGES = 5;

  // test clock limit kept by the controller, as a period
  localparam int TCK_MAX_MHZ       = 10;
  localparam int TCK_MIN_PERIOD_NS = 1000 / TCK_MAX_MHZ;

  // -------------------------------------------------------------------------
  // instruction codes
  // -------------------------------------------------------------------------
  localparam logic [2:0] IR_CAPTURE_ALL0 = 3'h0;
  localparam logic [2:0] IR_IDCODE       = 3'h1;
  localparam logic [2:0] IR_SAMPLE_HIZ   = 3'h2;
  localparam logic [2:0] IR_SAMPLE       = 3'h4;
  localparam logic [2:0] IR_BYPASS       = 3'h7;
  localparam logic [2:0] IR_CAPTURE_PAT  = 3'h1;
  localparam logic [2:0] IR_RESET_VAL    = IR_IDCODE;

  // -------------------------------------------------------------------------
  // identification word fields (values arbitrary, not a real maker)
  // -------------------------------------------------------------------------
  localparam logic [3:0]  ID_REVISION = 4'h0;
  localparam logic [4:0]  ID_DEPTH    = 5'h00;
  localparam logic [4:0]  ID_WIDTH    = 5'h00;
  localparam logic [5:0]  ID_PART     = 6'h00;
  localparam logic [10:0] ID_VENDOR   = 11'h3C1;
  localparam logic        ID_PRESENT  = 1'h1;

  // -------------------------------------------------------------------------
  // controller states, one-hot
  // -------------------------------------------------------------------------
  typedef enum logic [15:0] {
    ST_RESET      = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAPTURE_DR = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPDATE_DR  = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAPTURE_IR = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPDATE_IR  = 16'h8000
  } tap_state_t;

  // data register chosen by the active instruction
  typedef enum logic [2:0] {
    SEL_BYPASS = 3'h1,
    SEL_ID     = 3'h2,
    SEL_RING   = 3'h4
  } dr_sel_t;

endpackage

// ===== rtl/sram_boundary_scan_tap.sv
// reduced-function boundary scan port of a synchronous sram
// assumes test pins arrive on the test clock domain and that the sram core
// runs on clock; the port only observes the i/o ring and may ask for high-z
module sram_boundary_scan_tap
  import scan_tap_pkg::*;
#(
  parameter int RING_LEN = RING_LEN_X18
) (
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic                tck,
  input  wire logic                tms,
  input  wire logic                tdi,
  output logic                     tdo,
  output logic                     tdo_oe,
  output logic                     tms_pullup_en,
  output logic                     tdi_pullup_en,
  input  wire logic [RING_LEN-1:0] ring_pins,
  output logic                     sram_out_hiz
);

  // -------------------------------------------------------------------------
  // state of the test clock domain
  // -------------------------------------------------------------------------
  typedef struct packed {
    tap_state_t         state;
    logic [IR_LEN-1:0]  ir_shift;
    logic [IR_LEN-1:0]  ir;
    logic               bypass;
    logic [ID_LEN-1:0]  id_reg;
    logic [RING_LEN-1:0] ring_reg;
    logic               hiz_req;
  } tap_t;

  // falling-edge outputs kept apart so the rising-edge state stays clean
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } out_t;

  tap_t tap_ff;
  tap_t nxt_tap;
  out_t out_ff;
  out_t nxt_out;

  logic [RING_LEN-1:0] ring_sync;
  logic                hiz_sync;
  dr_sel_t             dr_sel;
  logic                dr_lsb;
  logic [ID_LEN-1:0]   id_word;

  // -------------------------------------------------------------------------
  // pin pull-ups
  // -------------------------------------------------------------------------
  // a floating mode-select walks the controller into reset and stays there
  assign tms_pullup_en = 1'b1;
  assign tdi_pullup_en = 1'b1;

  // -------------------------------------------------------------------------
  // ring pins into the test clock domain
  // -------------------------------------------------------------------------
  // the ring toggles at sram speed; capture may still see an old or new
  // value, but never a metastable one
  bit_sync #(
    .WIDTH (RING_LEN)
  ) u_ring_sync (
    .clock   (tck),
    .reset_n (reset_n),
    .din     (ring_pins),
    .dout    (ring_sync)
  );

  // -------------------------------------------------------------------------
  // hardwired identification word
  // -------------------------------------------------------------------------
  assign id_word = {ID_REVISION, ID_DEPTH, ID_WIDTH, ID_PART,
                    ID_VENDOR, ID_PRESENT};

  // -------------------------------------------------------------------------
  // instruction decode
  // -------------------------------------------------------------------------
  // unknown codes fall back to bypass so a chain never breaks
  always_comb begin
    case (tap_ff.ir)
      IR_CAPTURE_ALL0: dr_sel = SEL_RING;
      IR_IDCODE:       dr_sel = SEL_ID;
      IR_SAMPLE_HIZ:   dr_sel = SEL_RING;
      IR_SAMPLE:       dr_sel = SEL_RING;
      IR_BYPASS:       dr_sel = SEL_BYPASS;
      default:         dr_sel = SEL_BYPASS;
    endcase
  end

  // only one data register ever reaches the serial output
  always_comb begin
    case (dr_sel)
      SEL_ID:   dr_lsb = tap_ff.id_reg[0];
      SEL_RING: dr_lsb = tap_ff.ring_reg[0];
      default:  dr_lsb = tap_ff.bypass;
    endcase
  end

  // -------------------------------------------------------------------------
  // controller, registers, rising test clock
  // -------------------------------------------------------------------------
  always_comb begin
    nxt_tap = tap_ff;

    // standard sixteen-state walk; five highs reach reset from anywhere
    case (tap_ff.state)
      ST_RESET:      nxt_tap.state = tms ? ST_RESET   : ST_IDLE;
      ST_IDLE:       nxt_tap.state = tms ? ST_SEL_DR  : ST_IDLE;
      ST_SEL_DR:     nxt_tap.state = tms ? ST_SEL_IR  : ST_CAPTURE_DR;
      ST_CAPTURE_DR: nxt_tap.state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR:   nxt_tap.state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR:   nxt_tap.state = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:   nxt_tap.state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR:   nxt_tap.state = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR:  nxt_tap.state = tms ? ST_SEL_DR  : ST_IDLE;
      ST_SEL_IR:     nxt_tap.state = tms ? ST_RESET   : ST_CAPTURE_IR;
      ST_CAPTURE_IR: nxt_tap.state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR:   nxt_tap.state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR:   nxt_tap.state = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:   nxt_tap.state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR:   nxt_tap.state = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR:  nxt_tap.state = tms ? ST_SEL_DR  : ST_IDLE;
      default:       nxt_tap.state = ST_RESET;
    endcase

    // instruction path and its capture pattern
    case (tap_ff.state)
      ST_RESET: begin
        nxt_tap.ir = IR_RESET_VAL;
      end
      ST_CAPTURE_IR: begin
        nxt_tap.ir_shift = IR_CAPTURE_PAT;
      end
      ST_SHIFT_IR: begin
        nxt_tap.ir_shift = {tdi, tap_ff.ir_shift[IR_LEN-1:1]};
      end
      ST_UPDATE_IR: begin
        nxt_tap.ir = tap_ff.ir_shift;
      end
      default: begin
        nxt_tap.ir = tap_ff.ir;
      end
    endcase

    // the identification code stands from the very edge that enters reset,
    // so a test clock parked right after five highs never leaves high-z on
    if (nxt_tap.state == ST_RESET) begin
      nxt_tap.ir = IR_RESET_VAL;
    end

    // data path: capture then shift the one selected register
    case (tap_ff.state)
      ST_CAPTURE_DR: begin
        case (dr_sel)
          SEL_ID:   nxt_tap.id_reg   = id_word;
          SEL_RING: nxt_tap.ring_reg = ring_sync;
          default:  nxt_tap.bypass   = 1'b0;
        endcase
      end
      ST_SHIFT_DR: begin
        case (dr_sel)
          SEL_ID: begin
            nxt_tap.id_reg = {tdi, tap_ff.id_reg[ID_LEN-1:1]};
          end
          SEL_RING: begin
            nxt_tap.ring_reg = {tdi, tap_ff.ring_reg[RING_LEN-1:1]};
          end
          default: begin
            nxt_tap.bypass = tdi;
          end
        endcase
      end
      // no preload: update-dr leaves every register as in pause-dr
      ST_UPDATE_DR: begin
        nxt_tap.ring_reg = tap_ff.ring_reg;
      end
      default: begin
        nxt_tap.bypass = tap_ff.bypass;
      end
    endcase

    // high-z request follows the active instruction; outputs only disabled
    nxt_tap.hiz_req = (nxt_tap.ir == IR_CAPTURE_ALL0) ||
                      (nxt_tap.ir == IR_SAMPLE_HIZ);
  end

  // power-up puts the controller in reset with the identification code
  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      tap_ff.state    <= ST_RESET;
      tap_ff.ir_shift <= '0;
      tap_ff.ir       <= IR_RESET_VAL;
      tap_ff.bypass   <= 1'b0;
      tap_ff.id_reg   <= '0;
      tap_ff.ring_reg <= '0;
      tap_ff.hiz_req  <= 1'b0;
    end else begin
      tap_ff <= nxt_tap;
    end
  end

  // -------------------------------------------------------------------------
  // serial output, falling test clock
  // -------------------------------------------------------------------------
  // changing on the falling edge gives the next device half a period of setup
  always_comb begin
    nxt_out = out_ff;
    case (tap_ff.state)
      ST_SHIFT_IR: begin
        nxt_out.tdo    = tap_ff.ir_shift[0];
        nxt_out.tdo_oe = 1'b1;
      end
      ST_SHIFT_DR: begin
        nxt_out.tdo    = dr_lsb;
        nxt_out.tdo_oe = 1'b1;
      end
      default: begin
        nxt_out.tdo    = 1'b0;
        nxt_out.tdo_oe = 1'b0;
      end
    endcase
  end

  always_ff @(negedge tck or negedge reset_n) begin
    if (!reset_n) begin
      out_ff <= '0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  assign tdo    = out_ff.tdo;
  assign tdo_oe = out_ff.tdo_oe;

  // -------------------------------------------------------------------------
  // high-z request into the sram clock domain
  // -------------------------------------------------------------------------
  // a level, so two flops are enough; the sram never sees test clock logic
  bit_sync #(
    .WIDTH (1)
  ) u_hiz_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .din     (tap_ff.hiz_req),
    .dout    (hiz_sync)
  );

  assign sram_out_hiz = hiz_sync;

endmodule

// ===== testbench/scan_master.sv
// behavioural board scan controller driving the test pins
// assumes the controller is parked in run-test-idle between scans
module scan_master (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // one tck period per step; tck stands low outside frames
  // ---------------------------------------------------------------
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // change after the fall, read tdo just before the rise
  // 6 ns per step, well past the board limit: the logic has no pad timing
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #3;
    o   = tdo;
    tck = 1'b1;
    #3;
    tck = 1'b0;
  endtask
  // free walk by a tms list, lsb first; released tdi shows its pull-up
  task automatic walk(input logic [31:0] m, input int n);
    logic o;
    for (int i = 0; i < n; i++) begin
      step(m[i], 1'b0, o);
    end
    tdi = 1'b1;
  endtask
  // idle to idle scan of n bits, first bit out is the register lsb
  task automatic scan(input logic ir, input logic [71:0] din, input int n,
                      output logic [71:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b1, o);
    if (ir) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      step(1'(i == n - 1), din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    tdi = 1'b1;
  endtask
endmodule

// ===== testbench/tap_props.sv
// assertions on the pins of the boundary scan port, all in the tck domain
// assumes tck stands low between frames and reset_n clears both domains
module tap_props
  import scan_tap_pkg::*;
#(
  parameter int RING_LEN = RING_LEN_X18
) (
  input wire logic                clock,
  input wire logic                reset_n,
  input wire logic                tck,
  input wire logic                tms,
  input wire logic                tdi,
  input wire logic                tdo,
  input wire logic                tdo_oe,
  input wire logic                tms_pullup_en,
  input wire logic                tdi_pullup_en,
  input wire logic [RING_LEN-1:0] ring_pins,
  input wire logic                sram_out_hiz
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // controller walks, counted in rising tck edges
  // ---------------------------------------------------------------
  default clocking cb @(posedge tck); endclocking
  default disable iff (!reset_n);
  sequence s_tlr; tms [*5]; endsequence
  sequence s_to_shdr; !tms ##1 tms ##1 !tms ##1 !tms; endsequence
  sequence s_to_shir; !tms ##1 tms ##1 tms ##1 !tms ##1 !tms; endsequence
  // outputs set on the fall are seen at the next rise
  a_pullups_on: assert property (tms_pullup_en && tdi_pullup_en)
    else $error("pull-up enable dropped");
  a_reset_quiet: assert property (s_tlr |=> !tdo_oe && !tdo)
    else $error("output active after mode-select reset");
  a_id_first_bit: assert property (s_tlr ##1 s_to_shdr |=> tdo_oe && tdo)
    else $error("identification bit zero not shown first");
  a_ir_capture_pat: assert property (s_tlr ##1 s_to_shir |=> tdo ##1 !tdo)
    else $error("instruction capture pattern wrong");
  a_tdo_quiet: assert property (!tdo_oe |-> !tdo)
    else $error("serial output not quiet outside shift");
  a_exit_disables: assert property (tdo_oe && tms |=> !tdo_oe)
    else $error("output stays enabled after leaving shift");
  a_shift_holds: assert property (tdo_oe && !tms |=> tdo_oe)
    else $error("shift left with mode-select low");
  a_oe_needs_shift: assert property ($rose(tdo_oe) |-> !$past(tms))
    else $error("output enabled without entering shift");
  // ir is back to identification, so the sram drivers are released
  a_hiz_released: assert property (s_tlr ##1 tms [*8] |-> !sram_out_hiz)
    else $error("high-z kept after mode-select reset");
endmodule

bind sram_boundary_scan_tap tap_props #(.RING_LEN(RING_LEN)) tap_props_i (
  .clock(clock), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
  .tdo_oe(tdo_oe), .tms_pullup_en(tms_pullup_en), .tdi_pullup_en(tdi_pullup_en),
  .ring_pins(ring_pins), .sram_out_hiz(sram_out_hiz));

// ===== testbench/tb_top.sv
// self-checking bench for the sram boundary scan port
// assumes the scan_master model owns the test pins and the bench the rest
module tb_top
  import scan_tap_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RL = RING_LEN_X18;
  localparam logic [31:0] ID_EXP = {ID_REVISION, ID_DEPTH, ID_WIDTH, ID_PART,
                                    ID_VENDOR, ID_PRESENT};
  typedef struct {logic [2:0] code; logic hiz; int len;} row_t;
  // ---------------------------------------------------------------
  // every code: expected high-z and selected chain length
  // ---------------------------------------------------------------
  // reserved codes are loaded only here, to show the chain stays whole
  row_t rows[8] = '{'{3'h0, 1'b1, RL}, '{3'h1, 1'b0, 32}, '{3'h2, 1'b1, RL},
                    '{3'h3, 1'b0, 1}, '{3'h4, 1'b0, RL}, '{3'h5, 1'b0, 1},
                    '{3'h6, 1'b0, 1}, '{3'h7, 1'b0, 1}};
  logic          clock = 1'b0;
  logic          reset_n;
  logic          tck, tms, tdi, tdo, tdo_oe, tms_pu, tdi_pu, hiz;
  logic [RL-1:0] ring_pins;
  int            err_count = 0;
  int            n_tests = 0;
  always #5 clock = ~clock;
  scan_master scan_master_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  sram_boundary_scan_tap #(.RING_LEN(RL)) sram_boundary_scan_tap_i (
    .clock(clock), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .tms_pullup_en(tms_pu), .tdi_pullup_en(tdi_pu),
    .ring_pins(ring_pins), .sram_out_hiz(hiz));
  task automatic check(input string what, input logic [71:0] seen,
                       input logic [71:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [71:0] cap_of(input int len);
    if (len == 32) return 72'(ID_EXP);
    if (len == RL) return 72'(ring_pins);
    return 72'h0;
  endfunction
  // hiz crosses into the core clock, so give the synchroniser time
  task automatic hiz_is(input logic e);
    repeat (4) @(posedge clock);
    #1;
    check("hiz", 72'(hiz), 72'(e));
  endtask
  task automatic ir_load(input logic [2:0] code);
    logic [71:0] dout;
    scan_master_i.scan(1'b1, 72'(code), 3, dout);
    check("ir capture", 72'(dout[1:0]), 72'h1);
  endtask
  // 8 marker bits behind the capture prove both length and content
  task automatic dr_check(input int len, input logic [71:0] cap);
    logic [71:0] din, dout, mask;
    din  = {9{8'hA5}};
    mask = (72'h1 << (len + 8)) - 72'h1;
    scan_master_i.scan(1'b0, din, len + 8, dout);
    check("dr chain", dout & mask, ((din << len) | cap) & mask);
  endtask
  initial begin
    #150000;
    err_count++;
    final_report();
  end
  initial begin
    reset_n   = 1'b0;
    ring_pins = 51'h2A5C30F961E2D;
    repeat (20) @(posedge clock);
    #1;
    reset_n = 1'b1;
    @(posedge clock);
    #1;
    check("pull-ups", 72'({tms_pu, tdi_pu}), 72'h3);
    check("oe idle", 72'(tdo_oe), 72'h0);
    scan_master_i.walk(32'h1F, 6);
    dr_check(32, 72'(ID_EXP));
    foreach (rows[i]) begin
      ir_load(rows[i].code);
      hiz_is(rows[i].hiz);
      dr_check(rows[i].len, cap_of(rows[i].len));
    end
    // a changed ring must show in the next sample snapshot
    ir_load(IR_SAMPLE);
    @(posedge clock);
    #1;
    ring_pins = ~ring_pins;
    dr_check(RL, cap_of(RL));
    // instruction parked in pause-ir must not act before update
    scan_master_i.walk(32'h43, 9);
    hiz_is(1'b0);
    scan_master_i.walk(32'h3, 3);
    hiz_is(1'b1);
    // mode-select reset in mid-shift restores the identification path
    scan_master_i.walk(32'hFFF9, 17);
    hiz_is(1'b0);
    dr_check(32, 72'(ID_EXP));
    scan_master_i.walk(32'h1F, 6);
    ir_load(IR_BYPASS);
    dr_check(1, 72'h0);
    // reset reached on the fifth high from shift-dr, then tck parked
    ir_load(IR_SAMPLE_HIZ);
    hiz_is(1'b1);
    scan_master_i.walk(32'hF9, 8);
    hiz_is(1'b0);
    // power-up reset in mid-run with tck parked restores identification
    scan_master_i.walk(32'h0, 1);
    ir_load(IR_CAPTURE_ALL0);
    hiz_is(1'b1);
    reset_n = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    reset_n = 1'b1;
    hiz_is(1'b0);
    scan_master_i.walk(32'h0, 1);
    dr_check(32, 72'(ID_EXP));
    final_report();
  end
endmodule
